// >>> bench/hsw_ctrl_sva.sv
// Purpose: Port-level assertions for the hot swap control core
// Assumes: ce high; pins reach outputs 3 edges later
// Notes: Bound into every hsw_ctrl instance
`timescale 1ns/10ps
`default_nettype none
module hsw_ctrl_sva
  import hsw_pkg::*;
#(
  parameter int TEMP_PERIOD = TEMP_PERIOD_CYC,
  parameter int TEMP_PULSE = TEMP_PULSE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire hsw_pkg::hsw_sense_type sense_in,
  input wire hsw_pkg::hsw_cmd_type cmd_in,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic gate_on,
  input wire hsw_pkg::hsw_timer_drv_type timer_drv,
  input wire logic diode_pulse,
  input wire logic power_good_out_oe,
  input wire logic alert_line_oe,
  input wire logic latched_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  int gap_q;
  logic seen_q;
  // Cycles since last pulse start; first pulse has no reference
  always_ff @(posedge clk) begin
    if (reset) begin
      gap_q <= 0;
      seen_q <= 1'b0;
    end else if ($rose(diode_pulse)) begin
      gap_q <= 0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 1;
    end
  end
  sequence s_read(logic [7:0] c);
    cmd_in.valid && !cmd_in.write && cmd_in.code == c;
  endsequence
  sequence s_mask_all;
    cmd_in.valid && cmd_in.write && cmd_in.code == CMD_ALERT_MASK &&
    cmd_in.wdata[4:0] == 5'h1f ##1 !(cmd_in.valid && cmd_in.write);
  endsequence
  sequence s_expiry;
    (sense_in.limit_active && sense_in.timer_hi) [*4];
  endsequence
  AST_READ_ANSWER: assert property (s_read(cmd_in.code) |=> cmd_rvalid)
    else $error("no answer");
  AST_LATCH_DIAG: assert property (s_read(CMD_DIAG_WORD) |=>
    cmd_rdata[DG_LATCHED_OFF] == $past(latched_off))
    else $error("diag latch bit");
  AST_LATCH_HOLD: assert property (latched_off |->
    !gate_on && timer_drv.slow_discharge)
    else $error("latch drive");
  AST_FAULT_EXPIRY: assert property (s_expiry |-> !gate_on)
    else $error("gate on at expiry");
  AST_LIMIT_CHARGE: assert property ((gate_on && sense_in.limit_active &&
    !sense_in.timer_hi) [*4] |-> timer_drv.fault_charge)
    else $error("no fault charge");
  AST_LIMIT_END: assert property ((gate_on && !sense_in.limit_active) [*4]
    |-> timer_drv.fast_discharge && !timer_drv.fault_charge)
    else $error("no discharge");
  AST_UV_GATE: assert property ((!sense_in.undervoltage_enable_in) [*4]
    |-> !gate_on)
    else $error("gate on uv");
  AST_OV_GATE: assert property (sense_in.overvoltage_in [*4] |-> !gate_on)
    else $error("gate on ov");
  AST_PG_LOW: assert property ((!sense_in.undervoltage_enable_in ||
    sense_in.overvoltage_in) [*4] |-> power_good_out_oe)
    else $error("pg not low");
  AST_PG_HIGH: assert property ((sense_in.power_good_feedback_in &&
    sense_in.undervoltage_enable_in && !sense_in.overvoltage_in) [*4]
    |-> !power_good_out_oe)
    else $error("pg not high");
  AST_DIODE_PERIOD: assert property ($rose(diode_pulse) && seen_q |->
    gap_q == TEMP_PERIOD - 1)
    else $error("diode period");
  AST_DIODE_WIDTH: assert property ($fell(diode_pulse) |->
    gap_q == TEMP_PULSE - 1)
    else $error("diode width");
  AST_MASK_ALL: assert property (s_mask_all |=> !alert_line_oe)
    else $error("masked alert");
endmodule
bind hsw_ctrl hsw_ctrl_sva #(.TEMP_PERIOD(TEMP_PERIOD), .TEMP_PULSE(TEMP_PULSE))
  u_sva (.clk(clk), .reset(reset), .sense_in(sense_in), .cmd_in(cmd_in),
  .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .gate_on(gate_on),
  .timer_drv(timer_drv), .diode_pulse(diode_pulse),
  .power_good_out_oe(power_good_out_oe), .alert_line_oe(alert_line_oe),
  .latched_off(latched_off));
`default_nettype wire

// >>> bench/hsw_ctrl_tb_top.sv
// Purpose: Self-checking bench of the control core
// Assumes: Host commands as strobes, timer capacitor modelled
// Notes: Reads are scored by a queue monitor
`timescale 1ns/10ps
`default_nettype none
module hsw_ctrl_tb_top;
  import hsw_pkg::*;
  localparam logic [7:0] RC [5] = '{CMD_OVERTEMP_FAULT_LIMIT, CMD_OVERTEMP_WARN_LIMIT,
    CMD_ALERT_MASK, CMD_DEVICE_SETUP, 8'h20};
  localparam logic [15:0] RE [5] = '{16'h0096, 16'h007d, 16'h0000,
    16'h0000, 16'h0000};
  localparam logic [7:0] DS [9] = '{8'h00, 8'h80, 8'h90, 8'ha0, 8'hb0,
    8'hc0, 8'hd0, 8'h00, 8'he0};
  localparam int RS [9] = '{1, 0, 1, 0, 1, 0, 1, 0, 1};
  localparam int NR [9] = '{0, 0, 1, 2, 4, 8, 16, 2, 2};
  localparam int LT [9] = '{1, 1, 1, 1, 1, 1, 1, 0, 0};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic limit = 1'b0;
  logic uv_en = 1'b1;
  logic ov = 1'b0;
  logic fb = 1'b1;
  logic rsel = 1'b1;
  wire logic t_hi, t_mid, t_lo;
  hsw_sense_type sense;
  hsw_cmd_type cmd = '0;
  hsw_temp_type temp = '0;
  logic [15:0] cmd_rdata;
  logic cmd_rvalid, gate_on, diode_pulse, pg_oe, alert_oe, latched_off;
  hsw_timer_drv_type timer_drv;
  logic [15:0] exp_q [$];
  logic [15:0] msk_q [$];
  int mismatches = 0;
  int cmp_count = 0;
  logic [15:0] tv;
  assign sense = '{limit, t_hi, t_mid, t_lo, uv_en, ov, fb, rsel};
  hsw_ctrl #(.TEMP_PERIOD(20), .TEMP_PULSE(2)) DUT (
    .clk(clk), .reset(reset), .ce(ce), .sense_in(sense), .cmd_in(cmd),
    .temp_in(temp), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .gate_on(gate_on), .timer_drv(timer_drv), .diode_pulse(diode_pulse),
    .power_good_out(), .power_good_out_oe(pg_oe), .alert_line_out(),
    .alert_line_oe(alert_oe), .latched_off(latched_off));
  hsw_timer_model u_cap (.clk(clk), .reset(reset), .drv(timer_drv),
    .hi(t_hi), .mid(t_mid), .lo(t_lo));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
      input string what);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic send(input logic w, input logic [7:0] c,
      input logic [15:0] d);
    @(posedge clk);
    cmd <= '{1'b1, w, c, d};
    @(posedge clk);
    cmd.valid <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    send(1'b1, c, d);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e,
      input logic [15:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    send(1'b0, c, 16'h0000);
  endtask
  task automatic settemp(input logic [15:0] v);
    @(posedge clk);
    temp <= '{1'b1, v};
    @(posedge clk);
    temp.valid <= 1'b0;
  endtask
  // Bounded wait on gate (0), latched (1) or alert (2)
  task automatic wait_sig(input int s, input logic v, input int n);
    logic cur;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      cur = (s == 0) ? gate_on : (s == 1) ? latched_off : alert_oe;
      if (cur === v) return;
    end
    check(cur, v, "wait bound");
    close_out();
  endtask
  task automatic retry_case(input int n, input logic lt);
    int rises;
    int ramps;
    logic g0;
    logic f0;
    rises = 0;
    ramps = 0;
    g0 = gate_on;
    f0 = 1'b0;
    limit <= 1'b1;
    for (int k = 0; k < 12000; k++) begin
      @(posedge clk);
      if (latched_off === 1'b1 || (!lt && rises == n)) break;
      rises += int'(gate_on === 1'b1 && g0 === 1'b0);
      ramps += int'(gate_on === 1'b0 && timer_drv.fault_charge === 1'b1 &&
        f0 === 1'b0);
      g0 = gate_on;
      f0 = timer_drv.fault_charge;
    end
    check(16'(rises), 16'(n), "restarts");
    check(16'(ramps), 16'(7 * n), "ramps");
    check(latched_off, lt, "latched");
    limit <= 1'b0;
    if (lt) begin
      repeat (50) @(posedge clk);
      check(gate_on, 1'b0, "stays off");
      rd(CMD_DIAG_WORD, 16'h0010, 16'h0010);
      uv_en <= 1'b0;
      repeat (6) @(posedge clk);
      uv_en <= 1'b1;
      wait_sig(1, 1'b0, 50);
      wait_sig(0, 1'b1, 400);
    end
    repeat (80) @(posedge clk);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
  endtask
  always @(posedge clk) begin
    if (cmd_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(cmd_rvalid, 1'b0, "unasked answer");
      end else begin
        check(cmd_rdata & msk_q.pop_front(), exp_q.pop_front(), "read");
      end
    end
  end
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    tv = $urandom(32'h1fd6c21f);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    settemp(16'h0019);
    repeat (10) @(posedge clk);
    check(gate_on, 1'b0, "insertion gate");
    wait_sig(0, 1'b1, 300);
    foreach (RC[i]) rd(RC[i], RE[i], 16'hffff);
    fb <= 1'b0;
    repeat (5) @(posedge clk);
    check(pg_oe, 1'b1, "pg feedback low");
    rd(CMD_STATUS_WORD, 16'h0800, 16'h0800);
    rd(CMD_DIAG_WORD, 16'h0000, 16'h0080);
    fb <= 1'b1;
    repeat (5) @(posedge clk);
    check(pg_oe, 1'b0, "pg released");
    rd(CMD_DIAG_WORD, 16'h0080, 16'h0080);
    tv = {2'b01, 14'($urandom())};
    wr(CMD_OVERTEMP_WARN_LIMIT, tv);
    rd(CMD_OVERTEMP_WARN_LIMIT, tv, 16'hffff);
    tv = 16'h0020 + 16'($urandom() % 16);
    settemp(tv);
    rd(CMD_READ_TEMP, tv, 16'hffff);
    wr(CMD_OVERTEMP_WARN_LIMIT, tv);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    rd(CMD_DIAG_WORD, 16'h0000, 16'h0040);
    wr(CMD_OVERTEMP_WARN_LIMIT, tv - 16'h0001);
    wait_sig(2, 1'b1, 10);
    rd(CMD_DIAG_WORD, 16'h0040, 16'h0040);
    wr(CMD_OVERTEMP_FAULT_LIMIT, tv - 16'h0001);
    wait_sig(0, 1'b0, 10);
    rd(CMD_STATUS_WORD, 16'h0004, 16'h0004);
    wr(CMD_OVERTEMP_FAULT_LIMIT, 16'h0096);
    wr(CMD_OVERTEMP_WARN_LIMIT, 16'h007d);
    wait_sig(0, 1'b1, 200);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    wait_sig(2, 1'b0, 10);
    for (int i = 0; i < 4; i++) begin
      wr(CMD_ALERT_MASK, (i > 1) ? 16'h0006 : 16'h0000);
      {ov, uv_en} <= i[0] ? 2'b11 : 2'b00;
      wait_sig(0, 1'b0, 20);
      repeat (2) @(posedge clk);
      check(pg_oe, 1'b1, "pg forced");
      check(alert_oe, i < 2, "alert");
      rd(CMD_STATUS_INPUT, i[0] ? 16'h0080 : 16'h0010, 16'h0090);
      rd(CMD_DIAG_WORD, i[0] ? 16'h0100 : 16'h0200, 16'h0300);
      rd(CMD_STATUS_WORD, 16'h2000, 16'h2000);
      {ov, uv_en} <= 2'b01;
      wait_sig(0, 1'b1, 200);
      wr(CMD_CLEAR_FAULTS, 16'h0000);
    end
    wr(CMD_ALERT_MASK, 16'h0000);
    limit <= 1'b1;
    repeat (8) @(posedge clk);
    limit <= 1'b0;
    repeat (60) @(posedge clk);
    check(gate_on, 1'b1, "short limit");
    check(timer_drv.fast_discharge, 1'b1, "timer idle");
    for (int i = 0; i < 9; i++) begin
      rsel <= RS[i][0];
      wr(CMD_DEVICE_SETUP, DS[i]);
      retry_case(NR[i], LT[i][0]);
    end
    wr(CMD_ALERT_MASK, 16'h001f);
    repeat (4) @(posedge clk);
    check(16'(exp_q.size()), 16'h0000, "answers left");
    close_out();
  end
endmodule
`default_nettype wire

// >>> bench/hsw_timer_model.sv
// Purpose: Behavioural timer capacitor with its three comparators
// Assumes: Voltage in tenths of a volt, one step per clock
// Notes: Rates scaled down for short runs
`timescale 1ns/10ps
`default_nettype none
module hsw_timer_model
  import hsw_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire hsw_pkg::hsw_timer_drv_type drv,
  output wire logic hi,
  output wire logic mid,
  output wire logic lo
);
  int v;
  always @(posedge clk) begin
    if (reset) begin
      v <= 0;
    end else if (drv.insert_charge) begin
      v <= (v < 45) ? v + 1 : 45;
    end else if (drv.fault_charge) begin
      v <= (v < 44) ? v + 2 : 45;
    end else if (drv.fast_discharge) begin
      v <= (v > 4) ? v - 4 : 0;
    end else if (drv.slow_discharge) begin
      v <= (v > 0) ? v - 1 : 0;
    end
  end
  assign hi = (v >= 39);
  assign mid = (v > 11);
  // Restart only counts once the capacitor is nearly empty
  assign lo = (v < 3);
endmodule
`default_nettype wire

// >>> hw/hsw_ctrl.sv
// Purpose: Fault timer, restart, lockout, power good and temperature core
// Assumes: Analog comparators report timer levels and limiting as levels
// Notes: Gate and timer drives are requests to the analog front end
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Limiting active charges fault timer
// - Limiting ends early: discharge timer, run
// - Timer expiry: gate off, start restart
// - Retry pin high: latch off, discharge
// - Latch cleared by enable toggle, timer low
// - Latched-off diagnostic flag while latched
// - Seven ramps, eighth falling ramp re-enables
// - Fault persists: repeat timeout and restart
// - Retry pin selects none or unlimited
// - Setup register overrides retry count
// - Enable low holds gate; insertion first
// - Undervoltage sets status, diag, alert
// - Overvoltage gates off until it clears
// - Overvoltage sets status and diag bits
// - Alert mask suppresses each alert source
// - Enable release restarts with limiting
// - Feedback above threshold releases power good
// - Enable low or overvoltage forces power good low
// - Power good readable in two words
// - Pulse sense diode every millisecond
// - Read-temperature returns latest sample
// - Temperature warn alert, fault disables
module hsw_ctrl
  import hsw_pkg::*;
#(
  parameter int TEMP_PERIOD = TEMP_PERIOD_CYC,
  parameter int TEMP_PULSE = TEMP_PULSE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire hsw_pkg::hsw_sense_type sense_in,
  input wire hsw_pkg::hsw_cmd_type cmd_in,
  input wire hsw_pkg::hsw_temp_type temp_in,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic gate_on,
  output hsw_pkg::hsw_timer_drv_type timer_drv,
  output logic diode_pulse,
  output logic power_good_out,
  output logic power_good_out_oe,
  output logic alert_line_out,
  output logic alert_line_oe,
  output logic latched_off
);
  import hsw_pkg::*;

  hsw_state_type state_q;
  hsw_state_type state_d;
  hsw_sense_type sense;

  initial begin
    if (TEMP_PERIOD < 2 || TEMP_PERIOD >= (1 << TEMP_CNT_W)) begin
      $error("hsw_ctrl: TEMP_PERIOD out of range");
    end
    if (TEMP_PULSE < 1 || TEMP_PULSE >= TEMP_PERIOD) begin
      $error("hsw_ctrl: TEMP_PULSE out of range");
    end
  end

  // Comparator outputs may change at any time
  hsw_sync #(
    .WIDTH(SENSE_W)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .async_in(sense_in),
    .sync_out(sense)
  );

  // Codes 6 and 7 mean unlimited
  function automatic logic [RETRY_CNT_W-1:0] retry_limit(
    input logic [2:0] code
  );
    logic [RETRY_CNT_W-1:0] lim;
    lim = '0;
    case (code)
      3'h0: lim = 5'h00;
      3'h1: lim = 5'h01;
      3'h2: lim = 5'h02;
      3'h3: lim = 5'h04;
      3'h4: lim = 5'h08;
      3'h5: lim = 5'h10;
      default: lim = 5'h00;
    endcase
    return lim;
  endfunction

  logic en_ok;
  logic ot_fault_now;
  logic ot_warn_now;
  logic [2:0] retry_code;
  logic retry_allowed;
  logic [15:0] status_word;
  logic [7:0] status_input;
  logic [15:0] diag_word;
  logic latched_now;

  always_comb begin
    en_ok = sense.undervoltage_enable_in && !sense.overvoltage_in;
    ot_fault_now = $signed(state_q.temp_value) >
                   $signed(state_q.overtemp_fault_limit);
    ot_warn_now = $signed(state_q.temp_value) >
                  $signed(state_q.overtemp_warn_limit);
    if (state_q.device_setup[DS_RETRY_OVR]) begin
      retry_code = state_q.device_setup[DS_RETRY_LSB +: DS_RETRY_W];
    end else if (sense.retry_sel) begin
      retry_code = RETRY_CODE_NONE;
    end else begin
      retry_code = RETRY_CODE_INF;
    end
    retry_allowed = (retry_code >= RETRY_CODE_INF) ||
                    (state_q.retries_done <
                     retry_limit(retry_code));
    latched_now = (state_q.fsm == ST_LATCHED);
  end

  // Status images built from live state
  always_comb begin
    status_word = '0;
    status_word[SW_INPUT] = state_q.flag_uv || state_q.flag_ov ||
                            state_q.flag_oc;
    status_word[SW_POWER_GOOD_N] = !state_q.power_good;
    status_word[SW_TEMPERATURE] = state_q.flag_ot_warn ||
                                  state_q.flag_ot_fault;
    status_input = '0;
    status_input[SI_OVERVOLT] = state_q.flag_ov;
    status_input[SI_UNDERVOLT] = state_q.flag_uv;
    status_input[SI_OVERCURRENT] = state_q.flag_oc;
    diag_word = '0;
    diag_word[DG_OVERCURRENT] = state_q.flag_oc;
    diag_word[DG_UNDERVOLT] = state_q.flag_uv;
    diag_word[DG_OVERVOLT] = state_q.flag_ov;
    diag_word[DG_POWER_GOOD] = state_q.power_good;
    diag_word[DG_OT_WARN] = state_q.flag_ot_warn;
    diag_word[DG_OT_FAULT] = state_q.flag_ot_fault;
    diag_word[DG_LATCHED_OFF] = latched_now;
  end

  always_comb begin
    state_d = state_q;
    state_d.rvalid = 1'b0;

    // Clears first so a same-cycle event wins
    if (cmd_in.valid && cmd_in.write) begin
      case (cmd_in.code)
        CMD_CLEAR_FAULTS: begin
          state_d.flag_oc = 1'b0;
          state_d.flag_uv = 1'b0;
          state_d.flag_ov = 1'b0;
          state_d.flag_ot_warn = 1'b0;
          state_d.flag_ot_fault = 1'b0;
        end
        CMD_OVERTEMP_FAULT_LIMIT: state_d.overtemp_fault_limit = cmd_in.wdata;
        CMD_OVERTEMP_WARN_LIMIT: state_d.overtemp_warn_limit = cmd_in.wdata;
        CMD_ALERT_MASK: state_d.alert_mask = cmd_in.wdata;
        CMD_DEVICE_SETUP: state_d.device_setup = cmd_in.wdata[7:0];
        default: ;
      endcase
    end
    if (cmd_in.valid && !cmd_in.write) begin
      state_d.rvalid = 1'b1;
      case (cmd_in.code)
        CMD_OVERTEMP_FAULT_LIMIT: state_d.rdata = state_q.overtemp_fault_limit;
        CMD_OVERTEMP_WARN_LIMIT: state_d.rdata = state_q.overtemp_warn_limit;
        CMD_STATUS_WORD: state_d.rdata = status_word;
        CMD_STATUS_INPUT: state_d.rdata = {8'h00, status_input};
        CMD_READ_TEMP: state_d.rdata = state_q.temp_value;
        CMD_ALERT_MASK: state_d.rdata = state_q.alert_mask;
        CMD_DEVICE_SETUP: state_d.rdata = {8'h00, state_q.device_setup};
        CMD_DIAG_WORD: state_d.rdata = diag_word;
        default: state_d.rdata = 16'h0000;
      endcase
    end

    // Sample held until the next one
    if (state_q.temp_cnt == TEMP_CNT_W'(TEMP_PERIOD - 1)) begin
      state_d.temp_cnt = '0;
    end else begin
      state_d.temp_cnt = state_q.temp_cnt + 1'b1;
    end
    state_d.diode_pulse = (state_q.temp_cnt <
                           TEMP_CNT_W'(TEMP_PULSE));
    if (temp_in.valid) begin
      state_d.temp_value = temp_in.value;
    end

    // Sticky event flags
    if (ot_warn_now) begin
      state_d.flag_ot_warn = 1'b1;
    end
    if (ot_fault_now) begin
      state_d.flag_ot_fault = 1'b1;
    end
    if (sense.overvoltage_in) begin
      state_d.flag_ov = 1'b1;
    end
    // Undervolt only counts once insertion is over
    if (!sense.undervoltage_enable_in && state_q.fsm != ST_INSERT &&
        state_q.fsm != ST_INSERT_DIS) begin
      state_d.flag_uv = 1'b1;
    end
    if (!sense.undervoltage_enable_in) begin
      state_d.en_low_seen = 1'b1;
    end

    state_d.timer_drv = '0;
    state_d.gate_on = 1'b0;

    case (state_q.fsm)
      // Insertion delay
      ST_INSERT: begin
        state_d.timer_drv.insert_charge = 1'b1;
        if (sense.timer_hi) begin
          state_d.fsm = ST_INSERT_DIS;
        end
      end
      ST_INSERT_DIS: begin
        state_d.timer_drv.fast_discharge = 1'b1;
        if (sense.timer_lo) begin
          state_d.fsm = ST_WAIT_EN;
        end
      end
      // Gate held off until enable is good, no overtemperature fault and timer idle
      ST_WAIT_EN: begin
        state_d.timer_drv.fast_discharge = 1'b1;
        if (en_ok && !ot_fault_now && sense.timer_lo) begin
          state_d.fsm = ST_RUN;
          state_d.gate_on = 1'b1;
        end
      end
      ST_RUN: begin
        state_d.gate_on = 1'b1;
        if (!en_ok || ot_fault_now) begin
          state_d.gate_on = 1'b0;
          state_d.fsm = ST_WAIT_EN;
          state_d.retries_done = '0;
        end else if (sense.limit_active && sense.timer_hi) begin
          state_d.gate_on = 1'b0;
          state_d.flag_oc = 1'b1;
          state_d.ramp_cnt = '0;
          state_d.en_low_seen = 1'b0;
          if (retry_allowed) begin
            state_d.fsm = ST_RETRY_DN;
            state_d.timer_drv.slow_discharge = 1'b1;
          end else begin
            state_d.fsm = ST_LATCHED;
            state_d.timer_drv.slow_discharge = 1'b1;
          end
        end else if (sense.limit_active) begin
          state_d.timer_drv.fault_charge = 1'b1;
        end else begin
          state_d.timer_drv.fast_discharge = 1'b1;
          if (sense.timer_lo) begin
            state_d.retries_done = '0;
          end
        end
      end
      // Falling ramp; last of eight goes down to the low level
      ST_RETRY_DN: begin
        state_d.timer_drv.slow_discharge = 1'b1;
        if (state_q.ramp_cnt == 3'(RAMP_CYCLES)) begin
          if (sense.timer_lo) begin
            state_d.timer_drv.slow_discharge = 1'b0;
            state_d.fsm = ST_RUN;
            state_d.gate_on = 1'b1;
            state_d.retries_done = state_q.retries_done + 1'b1;
          end
        end else if (!sense.timer_mid) begin
          state_d.timer_drv.slow_discharge = 1'b0;
          state_d.timer_drv.fault_charge = 1'b1;
          state_d.fsm = ST_RETRY_UP;
        end
      end
      ST_RETRY_UP: begin
        state_d.timer_drv.fault_charge = 1'b1;
        if (sense.timer_hi) begin
          state_d.timer_drv.fault_charge = 1'b0;
          state_d.timer_drv.slow_discharge = 1'b1;
          state_d.ramp_cnt = state_q.ramp_cnt + 1'b1;
          state_d.fsm = ST_RETRY_DN;
        end
      end
      // Needs enable toggle and empty timer
      ST_LATCHED: begin
        state_d.timer_drv.slow_discharge = 1'b1;
        if (state_q.en_low_seen && sense.undervoltage_enable_in &&
            sense.timer_lo) begin
          state_d.fsm = ST_INSERT;
          state_d.timer_drv.slow_discharge = 1'b0;
          state_d.timer_drv.insert_charge = 1'b1;
          state_d.retries_done = '0;
          state_d.en_low_seen = 1'b0;
        end
      end
      default: begin
        state_d.fsm = ST_WAIT_EN;
      end
    endcase

    // Power good: feedback, qualified by enable and overvoltage
    state_d.power_good = sense.power_good_feedback_in &&
                         en_ok;

    state_d.alert =
      (state_d.flag_oc && !state_q.alert_mask[AM_OVERCURRENT]) ||
      (state_d.flag_uv && !state_q.alert_mask[AM_UNDERVOLT]) ||
      (state_d.flag_ov && !state_q.alert_mask[AM_OVERVOLT]) ||
      (state_d.flag_ot_warn && !state_q.alert_mask[AM_OT_WARN]) ||
      (state_d.flag_ot_fault &&
       !state_q.alert_mask[AM_OT_FAULT]);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= '0;
      state_q.fsm <= ST_INSERT;
      state_q.overtemp_fault_limit <= OT_FAULT_RESET;
      state_q.overtemp_warn_limit <= OT_WARN_RESET;
      state_q.alert_mask <= ALERT_MASK_RESET;
      state_q.device_setup <= DEVICE_SETUP_RESET;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Open-drain pins: driving means pulling low
  always_comb begin
    cmd_rdata = state_q.rdata;
    cmd_rvalid = state_q.rvalid;
    gate_on = state_q.gate_on;
    timer_drv = state_q.timer_drv;
    diode_pulse = state_q.diode_pulse;
    power_good_out = 1'b0;
    power_good_out_oe = !state_q.power_good;
    alert_line_out = 1'b0;
    alert_line_oe = state_q.alert;
    latched_off = (state_q.fsm == ST_LATCHED);
  end
endmodule
`default_nettype wire

// >>> hw/hsw_pkg.sv
// Purpose: Shared constants and types of the hot swap fault/restart core
// Assumes: 50 MHz clock, host commands arrive as decoded command strobes
// Notes: Temperatures are whole degrees Celsius, two's complement
package hsw_pkg;

  // Host command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OVERTEMP_FAULT_LIMIT = 8'h4f;
  localparam logic [7:0] CMD_OVERTEMP_WARN_LIMIT = 8'h51;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;
  localparam logic [7:0] CMD_READ_TEMP = 8'h8d;
  localparam logic [7:0] CMD_ALERT_MASK = 8'hd8;
  localparam logic [7:0] CMD_DEVICE_SETUP = 8'hd9;
  localparam logic [7:0] CMD_DIAG_WORD = 8'he1;

  // Summary status word fields
  localparam int SW_INPUT = 13;
  localparam int SW_POWER_GOOD_N = 11;
  localparam int SW_TEMPERATURE = 2;
  // Input fault status fields
  localparam int SI_OVERVOLT = 7;
  localparam int SI_UNDERVOLT = 4;
  localparam int SI_OVERCURRENT = 1;
  // Diagnostic status word fields
  localparam int DG_OVERCURRENT = 10;
  localparam int DG_UNDERVOLT = 9;
  localparam int DG_OVERVOLT = 8;
  localparam int DG_POWER_GOOD = 7;
  localparam int DG_OT_WARN = 6;
  localparam int DG_OT_FAULT = 5;
  localparam int DG_LATCHED_OFF = 4;
  // Alert mask fields: a set bit suppresses that alert
  localparam int AM_OVERCURRENT = 0;
  localparam int AM_UNDERVOLT = 1;
  localparam int AM_OVERVOLT = 2;
  localparam int AM_OT_WARN = 3;
  localparam int AM_OT_FAULT = 4;
  // Device setup: override enable and retry code
  localparam int DS_RETRY_OVR = 7;
  localparam int DS_RETRY_LSB = 4;
  localparam int DS_RETRY_W = 3;

  // Retry codes: 0,1,2,4,8,16 retries, then unlimited
  localparam logic [2:0] RETRY_CODE_NONE = 3'h0;
  localparam logic [2:0] RETRY_CODE_INF = 3'h6;
  localparam int RETRY_CNT_W = 5;
  localparam int RAMP_CYCLES = 7;

  // Reset values
  localparam logic [15:0] OT_WARN_RESET = 16'h007d;
  localparam logic [15:0] OT_FAULT_RESET = 16'h0096;
  localparam logic [15:0] ALERT_MASK_RESET = 16'h0000;
  localparam logic [7:0] DEVICE_SETUP_RESET = 8'h00;

  // Timing
  localparam int CLK_KHZ = 50000;
  localparam int TEMP_PERIOD_US = 1000;
  localparam int TEMP_PERIOD_CYC = (TEMP_PERIOD_US * CLK_KHZ) / 1000;
  localparam int TEMP_PULSE_US = 10;
  localparam int TEMP_PULSE_CYC = (TEMP_PULSE_US * CLK_KHZ) / 1000;
  localparam int TEMP_CNT_W = 20;

  // Comparator and pin inputs, all from outside the clock domain
  typedef struct packed {
    logic limit_active;
    logic timer_hi;
    logic timer_mid;
    logic timer_lo;
    logic undervoltage_enable_in;
    logic overvoltage_in;
    logic power_good_feedback_in;
    logic retry_sel;
  } hsw_sense_type;
  localparam int SENSE_W = 8;

  // Timer capacitor drive
  typedef struct packed {
    logic insert_charge;
    logic fault_charge;
    logic fast_discharge;
    logic slow_discharge;
  } hsw_timer_drv_type;

  // Host command request
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } hsw_cmd_type;

  // Converted temperature sample, same clock domain
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } hsw_temp_type;

  typedef enum logic [2:0] {
    ST_INSERT = 3'b000,
    ST_INSERT_DIS = 3'b001,
    ST_WAIT_EN = 3'b010,
    ST_RUN = 3'b011,
    ST_RETRY_DN = 3'b100,
    ST_RETRY_UP = 3'b101,
    ST_LATCHED = 3'b110
  } hsw_fsm_type;

  typedef struct packed {
    hsw_fsm_type fsm;
    logic [2:0] ramp_cnt;
    logic [RETRY_CNT_W-1:0] retries_done;
    logic en_low_seen;
    logic gate_on;
    hsw_timer_drv_type timer_drv;
    logic flag_oc;
    logic flag_uv;
    logic flag_ov;
    logic flag_ot_warn;
    logic flag_ot_fault;
    logic [15:0] overtemp_fault_limit;
    logic [15:0] overtemp_warn_limit;
    logic [15:0] alert_mask;
    logic [7:0] device_setup;
    logic [15:0] temp_value;
    logic [TEMP_CNT_W-1:0] temp_cnt;
    logic diode_pulse;
    logic power_good;
    logic alert;
    logic [15:0] rdata;
    logic rvalid;
  } hsw_state_type;

endpackage

// >>> hw/hsw_sync.sv
// Purpose: Two-flop synchroniser for a vector of slow levels
// Assumes: Each bit is an independent level
// Notes: Bits may arrive skewed by one cycle against each other
`timescale 1ns/10ps
`default_nettype none
module hsw_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } hsw_sync_state_type;

  hsw_sync_state_type state_q;
  hsw_sync_state_type state_d;

  initial begin
    if (WIDTH < 1) begin
      $error("hsw_sync: WIDTH must be at least 1");
    end
  end

  // First stage feeds only the second
  always_comb begin
    state_d = state_q;
    state_d.meta = async_in;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stable;
endmodule
`default_nettype wire
